// >>> common/cmg_pkg.sv
// Constants, types and decoding shared by the mode and fuse row guard
package cmg_pkg;
  // ****************************************************************
  // Protected row layout
  // ****************************************************************
  localparam int ROW_BYTES = 128;
  localparam int ROW_AW = 7;
  localparam logic [6:0] WP_BASE = 7'h20;
  localparam logic [6:0] WO_BASE = 7'h30;
  localparam logic [6:0] CFG_BASE = 7'h50;
  localparam logic [6:0] CFG_ADDR = 7'h50;
  localparam int CFG_DELIVERED = 0;
  localparam int CFG_DIS_OPT = 1;
  localparam int CFG_WP_LOCK = 2;
  localparam int CFG_CARD_OFF = 3;
  // ****************************************************************
  // Register map and fields
  // ****************************************************************
  localparam int AXI_AW = 8;
  localparam logic [7:0] OFF_MODE_CMD = 8'h00;
  localparam logic [7:0] OFF_PROC_STATUS_HIGH = 8'h04;
  localparam logic [7:0] OFF_ROW_ADDR = 8'h08;
  localparam logic [7:0] OFF_ROW_DATA = 8'h0c;
  localparam logic [7:0] OFF_ROW_LOCK = 8'h10;
  localparam int MODE_W = 3;
  localparam int ST_MODE = 0;
  localparam int ST_SSF = 3;
  localparam int ST_SMF = 4;
  localparam int ST_REFUSED = 5;
  localparam int ST_DELIVERED = 6;
  localparam int ST_WP_LOCK = 7;
  localparam int ST_CARD_OFF = 8;
  localparam int ST_TEST_AVAIL = 9;
  localparam int LK_WP = 0;
  localparam int LK_CARD_OFF = 1;
  localparam logic [2:0] CMD_ENTER_CLE = 3'h1;
  localparam logic [2:0] CMD_LEAVE_CLE = 3'h2;
  localparam logic [2:0] CMD_ENTER_USER = 3'h3;
  localparam logic [2:0] CMD_END_TEST = 3'h4;
  localparam logic [2:0] CMD_ENTER_BOOT = 3'h5;
  localparam logic [2:0] CMD_ENTER_TEST = 3'h6;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int BOOT_CYCLES = 4;
  // ****************************************************************
  // Types and decoding
  // ****************************************************************
  typedef enum logic [MODE_W-1:0] {
    MODE_BOOT, MODE_TEST, MODE_SYS, MODE_USER, MODE_CLE, MODE_HALT
  } cmg_mode_e;
  typedef enum logic [1:0] {RG_RO, RG_WP, RG_WO, RG_CFG} cmg_region_e;

  function automatic cmg_region_e cmg_region(input logic [6:0] a);
    if (a < WP_BASE)
      return RG_RO;
    else if (a < WO_BASE)
      return RG_WP;
    else if (a < CFG_BASE)
      return RG_WO;
    else
      return RG_CFG;
  endfunction
endpackage

// >>> common/cmg_row_if.sv
// Row write check carrier between the guard top and its row checker
`timescale 1ns/1ps
`default_nettype none
interface cmg_row_if;
  logic [6:0] addr;
  logic [7:0] old_byte;
  logic [7:0] wr_byte;
  logic factory;
  logic fw;
  logic wp_lock;
  logic allow;
  logic [7:0] new_byte;
  modport top (output addr, old_byte, wr_byte, factory, fw, wp_lock,
               input allow, new_byte);
  modport guard (input addr, old_byte, wr_byte, factory, fw, wp_lock,
                 output allow, new_byte);
endinterface
`default_nettype wire

// >>> hw/cmg_row_guard.sv
// Write permission and merge for one byte of the protected rows
`timescale 1ns/1ps
`default_nettype none
module cmg_row_guard
  import cmg_pkg::*;
(
  cmg_row_if.guard rif
);
  // ****************************************************************
  // Permission per region
  // ****************************************************************
  always_comb
  begin
    rif.allow = 1'b0;
    rif.new_byte = rif.old_byte;
    if (rif.factory)
    begin
      // Factory test software sets up every row, fuses included
      rif.allow = 1'b1;
      rif.new_byte = rif.wr_byte;
    end
    else if (rif.fw)
    begin
      case (cmg_region(rif.addr))
        RG_WP:
        begin
          if (!rif.wp_lock)
          begin
            rif.allow = 1'b1;
            rif.new_byte = rif.wr_byte;
          end
        end
        RG_WO:
        begin
          // Only ones can be added, so a set bit never returns to zero
          rif.allow = 1'b1;
          rif.new_byte = rif.old_byte | rif.wr_byte;
        end
        default:
        begin
          // Read-only area and fuse configuration stay untouched
          rif.allow = 1'b0;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// >>> hw/cmg_top.sv
// CPU mode guard and protected fuse rows behind an AXI4-Lite slave
//
// Functional notes
// - Reset always starts in hidden boot mode
// - Boot leaves to test mode when available
// - Otherwise boot leaves to system mode (a disabled card halts instead)
// - No way back into boot from other modes
// - Delivered parts never enter test mode
// - Boot mode only during start-up after reset
// - Later, only test and contactless emulation are super-system
// - Super-system flag set in boot, test, emulation
// - Top 128 row bytes excluded from firmware space
// - 32-byte area readable, never writable by firmware
// - 16-byte area writable until firmware locks it
// - 32-byte write-once area, bits only set
// - Disabled card refuses every later firmware start
// - Firmware cannot change security configuration fuses
// - Factory key area gets no hardware protection
// - System flag marks system mode; both clear user
//
// Chosen here: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module cmg_top
  import cmg_pkg::*;
#(
  parameter int NVM_BYTES = 65536,
  parameter int NVM_AW = 16,
  parameter int BOOT_WAIT = BOOT_CYCLES,
  parameter bit CLE_EN = 1'b1
)
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic por,
  input wire logic test_avail_pin,
  input wire logic [AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [NVM_AW-1:0] nvm_addr,
  output logic nvm_grant,
  output logic [MODE_W-1:0] cpu_mode,
  output logic super_system_flag,
  output logic system_mode_flag,
  output logic fw_run,
  output logic test_sw_run
);
  localparam int BCW = $clog2(BOOT_WAIT + 1);
  localparam logic [BCW-1:0] BOOT_LAST = BCW'(BOOT_WAIT - 1);
  localparam logic [NVM_AW-1:0] FW_LIMIT = NVM_AW'(NVM_BYTES - ROW_BYTES);

  function automatic logic is_mapped(input logic [AXI_AW-1:0] a);
    return (a == OFF_MODE_CMD) || (a == OFF_PROC_STATUS_HIGH) ||
           (a == OFF_ROW_ADDR) || (a == OFF_ROW_DATA) ||
           (a == OFF_ROW_LOCK);
  endfunction

  // ****************************************************************
  // Pin synchroniser
  // ****************************************************************
  logic tst_meta_ff;
  logic tst_sync_ff;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      tst_meta_ff <= 1'b0;
      tst_sync_ff <= 1'b0;
    end
    else
    begin
      tst_meta_ff <= test_avail_pin;
      tst_sync_ff <= tst_meta_ff;
    end
  end

  // ****************************************************************
  // Protected rows
  // ****************************************************************
  // Non-volatile: rst leaves the rows alone, only por blanks them
  logic [7:0] row_mem [ROW_BYTES];
  logic [7:0] cfg_byte;
  logic delivered;
  logic wp_lock;
  logic card_off;
  logic [ROW_AW-1:0] row_addr_ff;

  assign cfg_byte = row_mem[CFG_ADDR];
  assign delivered = cfg_byte[CFG_DELIVERED];
  assign wp_lock = cfg_byte[CFG_WP_LOCK];
  assign card_off = cfg_byte[CFG_DIS_OPT] && cfg_byte[CFG_CARD_OFF];

  // Rows lie above the firmware window; the factory key area lies
  // below it and is granted like any other firmware byte
  assign nvm_grant = (nvm_addr < FW_LIMIT);

  // ****************************************************************
  // Write channel of the register slave
  // ****************************************************************
  logic aw_got_ff;
  logic w_got_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic [AXI_AW-1:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic wr_go;
  logic wr_lane;

  assign s_axi_awready = !aw_got_ff && !bvalid_ff;
  assign s_axi_wready = !w_got_ff && !bvalid_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign wr_go = aw_got_ff && w_got_ff && !bvalid_ff;
  // All writable fields sit in byte lane 0; other lanes carry nothing
  assign wr_lane = wr_go && wstrb_ff[0];

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      aw_got_ff <= 1'b0;
      awaddr_ff <= '0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_got_ff <= 1'b1;
      awaddr_ff <= s_axi_awaddr;
    end
    else if (wr_go)
      aw_got_ff <= 1'b0;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      w_got_ff <= 1'b0;
      wdata_ff <= '0;
      wstrb_ff <= '0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_got_ff <= 1'b1;
      wdata_ff <= s_axi_wdata;
      wstrb_ff <= s_axi_wstrb;
    end
    else if (wr_go)
      w_got_ff <= 1'b0;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end
    else if (wr_go)
    begin
      bvalid_ff <= 1'b1;
      bresp_ff <= is_mapped(awaddr_ff) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready)
      bvalid_ff <= 1'b0;
  end

  logic cmd_wr;
  logic status_wr;
  logic addr_wr;
  logic data_wr;
  logic lock_wr;

  assign cmd_wr = wr_lane && (awaddr_ff == OFF_MODE_CMD);
  assign status_wr = wr_lane && (awaddr_ff == OFF_PROC_STATUS_HIGH);
  assign addr_wr = wr_lane && (awaddr_ff == OFF_ROW_ADDR);
  assign data_wr = wr_lane && (awaddr_ff == OFF_ROW_DATA);
  assign lock_wr = wr_lane && (awaddr_ff == OFF_ROW_LOCK);

  // ****************************************************************
  // Mode state machine
  // ****************************************************************
  cmg_mode_e mode_ff;
  cmg_mode_e nxt_mode;
  logic [BCW-1:0] boot_cnt_ff;
  logic boot_done;
  logic cmd_refused;

  assign boot_done = (boot_cnt_ff == BOOT_LAST);

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      boot_cnt_ff <= '0;
    else if (mode_ff == MODE_BOOT && !boot_done)
      boot_cnt_ff <= boot_cnt_ff + BCW'(1);
  end

  always_comb
  begin
    nxt_mode = mode_ff;
    cmd_refused = 1'b0;
    case (mode_ff)
      MODE_BOOT:
      begin
        // Waits for the synchronised pin before deciding
        if (boot_done)
        begin
          if (tst_sync_ff && !delivered)
            nxt_mode = MODE_TEST;
          else if (card_off)
            nxt_mode = MODE_HALT;
          else
            nxt_mode = MODE_SYS;
        end
        cmd_refused = cmd_wr;
      end
      MODE_HALT:
        cmd_refused = cmd_wr;
      default:
      begin
        if (cmd_wr)
        begin
          case (wdata_ff[2:0])
            CMD_ENTER_CLE:
            begin
              if (CLE_EN && (mode_ff == MODE_SYS || mode_ff == MODE_USER))
                nxt_mode = MODE_CLE;
              else
                cmd_refused = 1'b1;
            end
            CMD_LEAVE_CLE:
            begin
              if (mode_ff == MODE_CLE)
                nxt_mode = MODE_SYS;
              else
                cmd_refused = 1'b1;
            end
            CMD_ENTER_USER:
            begin
              if (mode_ff == MODE_SYS)
                nxt_mode = MODE_USER;
              else
                cmd_refused = 1'b1;
            end
            CMD_END_TEST:
            begin
              if (mode_ff == MODE_TEST)
                nxt_mode = card_off ? MODE_HALT : MODE_SYS;
              else
                cmd_refused = 1'b1;
            end
            default:
            begin
              // Boot and test are reached only from reset, never by
              // software, so both requests land here
              cmd_refused = 1'b1;
            end
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      mode_ff <= MODE_BOOT;
    else
      mode_ff <= nxt_mode;
  end

  logic ssf_ff;
  logic smf_ff;
  logic fw_run_ff;
  logic test_run_ff;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      ssf_ff <= 1'b1;
      smf_ff <= 1'b0;
      fw_run_ff <= 1'b0;
      test_run_ff <= 1'b0;
    end
    else
    begin
      ssf_ff <= (nxt_mode == MODE_BOOT) || (nxt_mode == MODE_TEST) ||
                (nxt_mode == MODE_CLE);
      smf_ff <= (nxt_mode == MODE_SYS);
      fw_run_ff <= (nxt_mode == MODE_SYS) || (nxt_mode == MODE_USER) ||
                   (nxt_mode == MODE_CLE);
      test_run_ff <= (nxt_mode == MODE_TEST);
    end
  end

  assign cpu_mode = mode_ff;
  assign super_system_flag = ssf_ff;
  assign system_mode_flag = smf_ff;
  assign fw_run = fw_run_ff;
  assign test_sw_run = test_run_ff;

  // ****************************************************************
  // Row access and locks
  // ****************************************************************
  cmg_row_if row_if ();

  assign row_if.addr = row_addr_ff;
  assign row_if.old_byte = row_mem[row_addr_ff];
  assign row_if.wr_byte = wdata_ff[7:0];
  assign row_if.factory = (mode_ff == MODE_TEST);
  assign row_if.fw = fw_run_ff;
  assign row_if.wp_lock = wp_lock;

  cmg_row_guard u_row_guard (
    .rif (row_if)
  );

  logic lock_ok;
  logic row_refused;
  logic lock_refused;
  logic [7:0] lock_byte;

  // Card disable only counts where the option fuse is set
  assign lock_ok = fw_run_ff &&
                   (!wdata_ff[LK_CARD_OFF] || cfg_byte[CFG_DIS_OPT]);
  assign row_refused = data_wr && !row_if.allow;
  assign lock_refused = lock_wr && !lock_ok;

  always_comb
  begin
    lock_byte = cfg_byte;
    lock_byte[CFG_WP_LOCK] = cfg_byte[CFG_WP_LOCK] | wdata_ff[LK_WP];
    lock_byte[CFG_CARD_OFF] = cfg_byte[CFG_CARD_OFF] |
                              wdata_ff[LK_CARD_OFF];
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      row_addr_ff <= '0;
    else if (addr_wr)
      row_addr_ff <= wdata_ff[ROW_AW-1:0];
  end

  always_ff @(posedge sys_clk)
  begin
    if (por)
    begin
      for (int i = 0; i < ROW_BYTES; i++)
        row_mem[i] <= '0;
    end
    else if (data_wr && row_if.allow)
      row_mem[row_addr_ff] <= row_if.new_byte;
    else if (lock_wr && lock_ok)
      row_mem[CFG_ADDR] <= lock_byte;
  end

  // Set wins over the software clear in the same cycle
  logic refused_ff;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      refused_ff <= 1'b0;
    else if (cmd_refused || row_refused || lock_refused)
      refused_ff <= 1'b1;
    else if (status_wr && wdata_ff[ST_REFUSED])
      refused_ff <= 1'b0;
  end

  // ****************************************************************
  // Read channel of the register slave
  // ****************************************************************
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic [31:0] rd_word;

  assign s_axi_arready = !rvalid_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  always_comb
  begin
    rd_word = '0;
    case (s_axi_araddr)
      OFF_PROC_STATUS_HIGH:
      begin
        rd_word[ST_MODE +: MODE_W] = mode_ff;
        rd_word[ST_SSF] = ssf_ff;
        rd_word[ST_SMF] = smf_ff;
        rd_word[ST_REFUSED] = refused_ff;
        rd_word[ST_DELIVERED] = delivered;
        rd_word[ST_WP_LOCK] = wp_lock;
        rd_word[ST_CARD_OFF] = card_off;
        rd_word[ST_TEST_AVAIL] = tst_sync_ff;
      end
      OFF_ROW_ADDR:
        rd_word[ROW_AW-1:0] = row_addr_ff;
      OFF_ROW_DATA:
        rd_word[7:0] = row_mem[row_addr_ff];
      OFF_ROW_LOCK:
      begin
        rd_word[LK_WP] = wp_lock;
        rd_word[LK_CARD_OFF] = cfg_byte[CFG_CARD_OFF];
      end
      default:
        rd_word = '0;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      rvalid_ff <= 1'b0;
      rdata_ff <= '0;
      rresp_ff <= RESP_OKAY;
    end
    else if (s_axi_arvalid && !rvalid_ff)
    begin
      rvalid_ff <= 1'b1;
      rdata_ff <= rd_word;
      rresp_ff <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rready)
      rvalid_ff <= 1'b0;
  end
endmodule
`default_nettype wire

// >>> dv/cmg_cpu_model.sv
// Bus master model of the processor core reaching the guard registers
`timescale 1ns/1ps
`default_nettype none
module cmg_cpu_model
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic req,
  input wire logic we,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  output logic done,
  output logic [31:0] rdata,
  output logic [1:0] resp,
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [7:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  // ********************************
  // One transfer at a time
  // ********************************
  logic busy_ff;
  always_ff @(posedge sys_clk)
  begin
    done <= 1'b0;
    if (rst)
    begin
      busy_ff <= 1'b0;
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid <= 1'b0;
      s_axi_bready <= 1'b0;
      s_axi_arvalid <= 1'b0;
      s_axi_rready <= 1'b0;
      s_axi_wstrb <= 4'hf;
    end
    else if (!busy_ff && req)
    begin
      busy_ff <= 1'b1;
      s_axi_awvalid <= we;
      s_axi_wvalid <= we;
      s_axi_bready <= we;
      s_axi_arvalid <= !we;
      s_axi_rready <= !we;
      s_axi_awaddr <= addr;
      s_axi_araddr <= addr;
      s_axi_wdata <= wdata;
    end
    else if (busy_ff)
    begin
      // A taken payload is inverted so no stale value passes for valid
      if (s_axi_awvalid && s_axi_awready)
      begin
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~s_axi_wdata;
      end
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~s_axi_araddr;
      end
      if (s_axi_bready && s_axi_bvalid)
      begin
        s_axi_bready <= 1'b0;
        resp <= s_axi_bresp;
        done <= 1'b1;
        busy_ff <= 1'b0;
      end
      if (s_axi_rready && s_axi_rvalid)
      begin
        s_axi_rready <= 1'b0;
        rdata <= s_axi_rdata;
        resp <= s_axi_rresp;
        done <= 1'b1;
        busy_ff <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// >>> dv/cmg_guard_chk.sv
// Concurrent checks on the mode and fuse row guard ports
`timescale 1ns/1ps
`default_nettype none
module cmg_guard_chk
  import cmg_pkg::*;
#(
  parameter int NVM_BYTES = 65536,
  parameter int NVM_AW = 16
)
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [NVM_AW-1:0] nvm_addr,
  input wire logic nvm_grant,
  input wire logic [MODE_W-1:0] cpu_mode,
  input wire logic super_system_flag,
  input wire logic system_mode_flag,
  input wire logic fw_run
);
  // ********************************
  // Mode and window checks
  // ********************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic ssm;
  assign ssm = cpu_mode inside {MODE_BOOT, MODE_TEST, MODE_CLE};
  a_ssf_tracks: assert property (super_system_flag == ssm)
    else $error("super-system flag disagrees with mode");
  a_smf_tracks: assert property (system_mode_flag == (cpu_mode == MODE_SYS))
    else $error("system flag disagrees with mode");
  a_fw_tracks: assert property (fw_run == (cpu_mode inside {MODE_SYS, MODE_USER, MODE_CLE}))
    else $error("firmware run flag disagrees with mode");
  a_boot_first: assert property ($past(rst) |-> cpu_mode == MODE_BOOT)
    else $error("mode after reset is not boot");
  a_no_reboot: assert property (cpu_mode != MODE_BOOT |=> cpu_mode != MODE_BOOT)
    else $error("boot mode entered after start-up");
  a_boot_short: assert property (cpu_mode == MODE_BOOT |-> ##[1:12] cpu_mode != MODE_BOOT)
    else $error("boot mode lasts too long");
  a_boot_exit: assert property (($past(cpu_mode) == MODE_BOOT && cpu_mode != MODE_BOOT) |-> cpu_mode inside {MODE_TEST, MODE_SYS, MODE_HALT})
    else $error("boot left to a wrong mode");
  a_test_entry: assert property ((cpu_mode == MODE_TEST && $past(cpu_mode) != MODE_TEST) |-> $past(cpu_mode) == MODE_BOOT)
    else $error("test mode entered outside boot");
  a_cle_entry: assert property ((cpu_mode == MODE_CLE && $past(cpu_mode) != MODE_CLE) |-> $past(cpu_mode) inside {MODE_SYS, MODE_USER})
    else $error("emulation mode entered from a wrong mode");
  a_halt_kept: assert property (cpu_mode == MODE_HALT |=> cpu_mode == MODE_HALT)
    else $error("disabled card left halt");
  a_row_window: assert property (nvm_grant == (nvm_addr < NVM_BYTES - 128))
    else $error("memory grant wrong for address");
  c_test: cover property (cpu_mode == MODE_TEST);
  c_cle: cover property (cpu_mode == MODE_CLE);
  c_user: cover property (cpu_mode == MODE_USER);
  c_halt: cover property (cpu_mode == MODE_HALT);
endmodule
bind cmg_top cmg_guard_chk #(.NVM_BYTES(NVM_BYTES), .NVM_AW(NVM_AW))
  cmg_guard_chk_inst (.sys_clk, .rst, .nvm_addr, .nvm_grant, .cpu_mode,
  .super_system_flag, .system_mode_flag, .fw_run);
`default_nettype wire

// >>> dv/tb_top.sv
// Self-checking bench for the mode and fuse row guard
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import cmg_pkg::*;
;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic por = 1'b1;
  logic test_avail_pin = 1'b0;
  logic [15:0] nvm_addr = 16'h0000;
  logic req = 1'b0;
  logic we = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic done, nvm_grant, super_system_flag, system_mode_flag, fw_run;
  logic test_sw_run, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] resp, s_axi_bresp, s_axi_rresp;
  logic [2:0] cpu_mode;
  logic [3:0] s_axi_wstrb;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] rdata, s_axi_wdata, s_axi_rdata;
  int n_fail = 0;
  int total_checks = 0;
  int cyc = 0;
  always #5 sys_clk = ~sys_clk;
  cmg_top cmg_top_inst (.sys_clk, .rst, .por, .test_avail_pin,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .nvm_addr, .nvm_grant, .cpu_mode,
    .super_system_flag, .system_mode_flag, .fw_run, .test_sw_run);
  cmg_cpu_model cmg_cpu_model_inst (.sys_clk, .rst, .req, .we, .addr, .wdata,
    .done, .rdata, .resp,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  // ********************************
  // Shared tasks
  // ********************************
  task automatic test_done();
    if (n_fail == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // A one-cycle request pulse; the model reports the answer with done
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    req <= 1'b1;
    we <= w;
    addr <= a;
    wdata <= d;
    @(posedge sys_clk);
    req <= 1'b0;
    while (done !== 1'b1)
      @(posedge sys_clk) #1;
  endtask
  task automatic mode_is(input cmg_mode_e m);
    chk("cpu_mode", 32'(m), 32'(cpu_mode));
    chk("ssf", 32'(m inside {MODE_BOOT, MODE_TEST, MODE_CLE}),
        32'(super_system_flag));
    chk("smf", 32'(m == MODE_SYS), 32'(system_mode_flag));
    chk("fw_run", 32'(m inside {MODE_SYS, MODE_USER, MODE_CLE}), 32'(fw_run));
    chk("test_sw_run", 32'(m == MODE_TEST), 32'(test_sw_run));
  endtask
  task automatic do_reset(input logic p, input logic pin, input cmg_mode_e m);
    @(posedge sys_clk);
    rst <= 1'b1;
    por <= p;
    test_avail_pin <= pin;
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    por <= 1'b0;
    @(posedge sys_clk) #1;
    mode_is(MODE_BOOT);
    for (int i = 0; i < 20 && cpu_mode === MODE_BOOT; i++)
      @(posedge sys_clk) #1;
    mode_is(m);
  endtask
  task automatic row_chk(input logic [7:0] a, input logic [7:0] e);
    bus(1'b1, OFF_ROW_ADDR, {24'h0, a});
    bus(1'b0, OFF_ROW_DATA, 32'h0);
    chk("row_byte", {24'h0, e}, {24'h0, rdata[7:0]});
  endtask
  task automatic row_try(input logic [7:0] a, input logic [7:0] d,
                         input logic [7:0] e, input logic r);
    bus(1'b1, OFF_PROC_STATUS_HIGH, 32'h20);
    bus(1'b1, OFF_ROW_ADDR, {24'h0, a});
    bus(1'b1, OFF_ROW_DATA, {24'h0, d});
    bus(1'b0, OFF_PROC_STATUS_HIGH, 32'h0);
    chk("row_refused", 32'(r), 32'(rdata[ST_REFUSED]));
    row_chk(a, e);
  endtask
  task automatic grant_is(input logic [15:0] a, input logic e);
    @(posedge sys_clk);
    nvm_addr <= a;
    @(posedge sys_clk) #1;
    chk("nvm_grant", 32'(e), 32'(nvm_grant));
  endtask
  // ********************************
  // Scenarios
  // ********************************
  task automatic t_factory();
    do_reset(1'b1, 1'b1, MODE_TEST);
    bus(1'b1, OFF_ROW_ADDR, 32'h05);
    bus(1'b1, OFF_ROW_DATA, 32'ha5);
    bus(1'b1, OFF_ROW_ADDR, 32'h50);
    bus(1'b1, OFF_ROW_DATA, 32'h03);
    bus(1'b1, OFF_MODE_CMD, 32'(CMD_END_TEST));
    mode_is(MODE_SYS);
    do_reset(1'b0, 1'b1, MODE_SYS);
  endtask
  task automatic t_mode_cmds();
    logic [2:0] cmd [10] = '{CMD_ENTER_BOOT, CMD_ENTER_TEST, CMD_END_TEST,
      3'h7, CMD_ENTER_CLE, CMD_ENTER_BOOT, CMD_LEAVE_CLE, CMD_ENTER_USER,
      CMD_ENTER_CLE, CMD_LEAVE_CLE};
    cmg_mode_e em [10] = '{MODE_SYS, MODE_SYS, MODE_SYS, MODE_SYS, MODE_CLE,
      MODE_CLE, MODE_SYS, MODE_USER, MODE_CLE, MODE_SYS};
    logic rf [10] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0,
      1'b0};
    for (int i = 0; i < 10; i++)
    begin
      bus(1'b1, OFF_PROC_STATUS_HIGH, 32'h20);
      bus(1'b1, OFF_MODE_CMD, 32'(cmd[i]));
      mode_is(em[i]);
      bus(1'b0, OFF_PROC_STATUS_HIGH, 32'h0);
      chk("refused", 32'(rf[i]), 32'(rdata[ST_REFUSED]));
      chk("status_mode", 32'(em[i]), 32'(rdata[2:0]));
    end
  endtask
  task automatic t_rows();
    row_try(8'h05, 8'h3c, 8'ha5, 1'b1);
    row_try(8'h1f, 8'hff, 8'h00, 1'b1);
    row_chk(8'h06, 8'h00);
    row_try(8'h50, 8'h00, 8'h03, 1'b1);
    row_try(8'h7f, 8'hff, 8'h00, 1'b1);
    row_try(8'h20, 8'h11, 8'h11, 1'b0);
    row_try(8'h2f, 8'h7e, 8'h7e, 1'b0);
    bus(1'b1, OFF_ROW_LOCK, 32'h1);
    row_try(8'h20, 8'h22, 8'h11, 1'b1);
    row_chk(8'h21, 8'h00);
    row_try(8'h30, 8'h05, 8'h05, 1'b0);
    row_try(8'h30, 8'h0a, 8'h0f, 1'b0);
    row_try(8'h30, 8'h00, 8'h0f, 1'b0);
    row_try(8'h4f, 8'h80, 8'h80, 1'b0);
  endtask
  task automatic t_window();
    grant_is(16'hff7f, 1'b1);
    grant_is(16'hff80, 1'b0);
    grant_is(16'hffff, 1'b0);
    grant_is(16'h0000, 1'b1);
    bus(1'b1, 8'h14, 32'h1);
    chk("bresp", 32'(RESP_SLVERR), 32'(resp));
    bus(1'b0, 8'h14, 32'h0);
    chk("rresp", 32'(RESP_SLVERR), 32'(resp));
    chk("rdata", 32'h0, rdata);
  endtask
  task automatic t_card_off();
    bus(1'b1, OFF_ROW_LOCK, 32'h2);
    bus(1'b0, OFF_ROW_LOCK, 32'h0);
    chk("card_off_bit", 32'h1, 32'(rdata[LK_CARD_OFF]));
    do_reset(1'b0, 1'b0, MODE_HALT);
    bus(1'b1, OFF_MODE_CMD, 32'(CMD_LEAVE_CLE));
    mode_is(MODE_HALT);
    do_reset(1'b0, 1'b1, MODE_HALT);
  endtask
  // ********************************
  // Main sequence and hang guard
  // ********************************
  initial
  begin
    t_factory();
    t_mode_cmds();
    t_rows();
    t_window();
    t_card_off();
    test_done();
  end
  // Whole run is well under a thousand cycles; this ceiling only catches a hang
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      n_fail++;
      test_done();
    end
  end
endmodule
`default_nettype wire
